// File: src/adcs_adc_control.sv
// converter control and status registers with Avalon-MM slave
//
// Summary of operation
// RL1 - start/busy field reads 00 when idle and ready for a command
// RL2 - writing 01 starts a conversion; field reads 01 while converting
// RL3 - writing 10 starts offset calibration; field reads 10 meanwhile
// RL4 - software selects 14-bit resolution before starting offset calibration
// RL5 - writing 11 starts gain calibration; field reads 11 meanwhile
// RL6 - dma select 0: reading result low byte drops the dma request
// RL7 - dma select 1: reading result high byte drops the dma request
// RL8 - interrupt select 0: window only; 1: end of conversion and window
// RL9 - averaging enable combines several samples per result, else one sample
// RL10 - sample count 00/01/10/11 gives 2/4/8/16 samples per result
// RL11 - power field 00 fast, 10 low power; reserved codes not written
// RL12 - scan bit converts each flagged input in turn; clear disables scanning
// RL13 - input arrangement field selects one of four input configurations
// RL14 - format 0 unsigned, 1 two's complement sign-extended result
// RL15 - resolution bit: clear single-pass 12-bit, set two-pass 14-bit
// RL16 - software writes 1 into reserved bit 0 of mode register
// RL17 - dma request raised on each new result, held until selected read
// RL18 - outside-window on fresh result above upper or below lower threshold
// RL19 - software starts calibration only with continuous conversion clear
// RL20 - field clears on finish; continuous mode keeps restarting conversions
// RL21 - averaged result is the mean, at configured resolution and format
`timescale 1ns/1ps

module adcs_adc_control
   import adcs_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic [ADDR_W-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output      logic [31:0]         avs_readdata,
   output      logic                avs_waitrequest,
   output      adcs_fe_req_s        feReq,
   input  wire adcs_fe_ans_s        feAns,
   output      logic                dmaReq,
   output      logic                irqPulse
);

   // ******************************************************
   // elaboration checks
   // ******************************************************
   if (ADDR_W < 14) begin : g_addr_check
      $error("adcs_adc_control: ADDR_W must be at least 14");
   end

   // ******************************************************
   // helper functions
   // ******************************************************

   // lowest flagged input of a scan mask
   function automatic logic [3:0] lowestSet(input logic [14:0] mask);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NCHAN - 1; i >= 0; i--) begin
         if (mask[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : lowestSet

   // mask with one input removed
   function automatic logic [14:0] dropBit(input logic [14:0] mask, input logic [3:0] idx);
      logic [14:0] m;
      m = mask;
      m[idx] = 1'b0;
      return m;
   endfunction : dropBit

   // unsigned value at the chosen resolution
   function automatic logic [15:0] plainValue(input logic [13:0] avg, input logic res14);
      return res14 ? {2'h0, avg} : {4'h0, avg[13:2]};  // see RL15
   endfunction : plainValue

   // presented value in the chosen format
   function automatic logic [15:0] fmtValue(input logic [13:0] avg, input logic res14, input logic sgn);
      logic [15:0] u;
      u = plainValue(avg, res14);
      if (sgn) begin
         return u - (res14 ? MID_14BIT : MID_12BIT);  // see RL14
      end
      return u;
   endfunction : fmtValue

   // ******************************************************
   // state and decode signals
   // ******************************************************
   adcs_state_s     s_ff;
   adcs_state_s     nxt_s;
   logic [11:0]     regIdx;
   logic            aligned;
   logic            taken;
   logic [7:0]      regRead;
   logic [14:0]     scanMask;
   logic            scanOn;
   logic            doConvStart;
   logic            resetSamples;
   logic [4:0]      nSamples;
   logic [2:0]      avgShift;
   logic [17:0]     sum;
   logic [17:0]     shifted;
   logic [13:0]     avg;
   logic [15:0]     uVal;
   logic            outside;

   // register index decode and scan mask
   assign regIdx   = avs_address[13:2];
   assign aligned  = (avs_address[1:0] == 2'h0) && (avs_address[ADDR_W-1:2] == (ADDR_W-2)'(regIdx));
   assign scanMask = {s_ff.selHigh, s_ff.selLow};
   assign scanOn   = s_ff.modeConfig[SCAN_BIT];

   // handshake: one wait cycle, then the request is taken
   assign avs_waitrequest = (avs_read || avs_write) && !s_ff.ack;
   assign taken           = (avs_read || avs_write) && s_ff.ack;

   // register read multiplexer, unmapped reads return zero
   always_comb begin
      regRead = 8'h00;
      if (aligned) begin
         case (regIdx)
            IDX_CMD_STATUS:  regRead = s_ff.cmdStatus;  // see RL1
            IDX_MODE_CONFIG: regRead = s_ff.modeConfig;
            IDX_RESULT_HIGH: regRead = s_ff.result[15:8];
            IDX_RESULT_LOW:  regRead = s_ff.result[7:0];
            IDX_SEL_HIGH:    regRead = {1'b0, s_ff.selHigh};
            IDX_SEL_LOW:     regRead = s_ff.selLow;
            IDX_WIN_UP_HIGH: regRead = s_ff.winUpper[15:8];
            IDX_WIN_UP_LOW:  regRead = s_ff.winUpper[7:0];
            IDX_WIN_LO_HIGH: regRead = s_ff.winLower[15:8];
            IDX_WIN_LO_LOW:  regRead = s_ff.winLower[7:0];
            default:         regRead = 8'h00;
         endcase
      end
   end

   // averaging arithmetic on the incoming sample
   always_comb begin
      avgShift = s_ff.cmdStatus[AVG_EN_BIT] ? (3'(s_ff.cmdStatus[AVG_CNT_HI:AVG_CNT_LO]) + 3'h1) : 3'h0;  // see RL9
      nSamples = 5'h1 << avgShift;  // see RL10
      sum      = s_ff.acc + 18'(feAns.data);
      shifted  = sum >> avgShift;  // see RL21
      avg      = shifted[13:0];
      uVal     = plainValue(avg, s_ff.modeConfig[RES_BIT]);
      outside  = (uVal > s_ff.winUpper) || (uVal < s_ff.winLower);  // see RL18
   end

   // ******************************************************
   // next-state logic
   // ******************************************************
   always_comb begin
      nxt_s          = s_ff;
      nxt_s.convReq  = 1'b0;
      nxt_s.calReq   = 1'b0;
      nxt_s.irqPulse = 1'b0;
      nxt_s.ack      = avs_waitrequest;
      doConvStart    = 1'b0;
      resetSamples   = 1'b0;

      // read data sampled during the wait cycle
      if (avs_waitrequest && avs_read) begin
         nxt_s.rdData = {24'h000000, regRead};
      end

      // register writes
      if (taken && avs_write && aligned) begin
         case (regIdx)
            IDX_CMD_STATUS: begin
               nxt_s.cmdStatus[DMA_SEL_BIT:0] = avs_writedata[DMA_SEL_BIT:0];
               if (s_ff.st == ST_IDLE) begin
                  case (avs_writedata[START_HI:START_LO])
                     START_CONVERT: begin
                        doConvStart = 1'b1;  // see RL2
                     end
                     START_CAL_OFFS, START_CAL_GAIN: begin
                        nxt_s.cmdStatus[START_HI:START_LO] = avs_writedata[START_HI:START_LO];  // see RL3 see RL5
                        nxt_s.calReq = 1'b1;
                        nxt_s.st     = ST_CAL_WAIT;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            IDX_MODE_CONFIG: begin
               nxt_s.modeConfig[SCAN_BIT:0] = avs_writedata[SCAN_BIT:0];
               // reserved power codes leave the level unchanged
               if (avs_writedata[POWER_LO] == 1'b0) begin
                  nxt_s.modeConfig[POWER_HI:POWER_LO] = avs_writedata[POWER_HI:POWER_LO];  // see RL11
               end
            end
            IDX_SEL_HIGH:    nxt_s.selHigh         = avs_writedata[6:0];
            IDX_SEL_LOW:     nxt_s.selLow          = avs_writedata[7:0];
            IDX_WIN_UP_HIGH: nxt_s.winUpper[15:8]  = avs_writedata[7:0];
            IDX_WIN_UP_LOW:  nxt_s.winUpper[7:0]   = avs_writedata[7:0];
            IDX_WIN_LO_HIGH: nxt_s.winLower[15:8]  = avs_writedata[7:0];
            IDX_WIN_LO_LOW:  nxt_s.winLower[7:0]   = avs_writedata[7:0];
            default: begin
            end
         endcase
      end

      // selected result byte read drops the dma request
      // a new result on the same edge sets it again, set wins
      if (taken && avs_read && aligned) begin
         if (!s_ff.cmdStatus[DMA_SEL_BIT] && regIdx == IDX_RESULT_LOW) begin
            nxt_s.dmaReq = 1'b0;  // see RL6
         end
         if (s_ff.cmdStatus[DMA_SEL_BIT] && regIdx == IDX_RESULT_HIGH) begin
            nxt_s.dmaReq = 1'b0;  // see RL7
         end
      end

      // sequencing of conversions and calibrations
      case (s_ff.st)
         ST_IDLE: begin
            // a done pulse while idle is ignored
         end
         ST_CONV_WAIT: begin
            // accumulate until the selected sample count is reached
            if (feAns.done) begin
               if (nxt_s.smpCnt + 5'h1 < nSamples) begin
                  nxt_s.acc     = sum;  // see RL9
                  nxt_s.smpCnt  = s_ff.smpCnt + 5'h1;
                  nxt_s.convReq = 1'b1;
               end else begin
                  nxt_s.result   = fmtValue(avg, s_ff.modeConfig[RES_BIT], s_ff.modeConfig[FORMAT_BIT]);  // see RL21
                  nxt_s.dmaReq   = 1'b1;  // see RL17
                  nxt_s.irqPulse = s_ff.cmdStatus[IRQ_SEL_BIT] || outside;  // see RL8
                  if (scanOn && s_ff.pending != 15'h0000) begin
                     nxt_s.chan    = lowestSet(s_ff.pending);  // see RL12
                     nxt_s.pending = dropBit(s_ff.pending, lowestSet(s_ff.pending));
                     nxt_s.convReq = 1'b1;
                     resetSamples  = 1'b1;
                  end else if (s_ff.cmdStatus[CONT_BIT]) begin
                     doConvStart = 1'b1;  // see RL20
                  end else begin
                     nxt_s.cmdStatus[START_HI:START_LO] = START_IDLE;  // see RL20
                     nxt_s.st = ST_IDLE;
                  end
               end
            end
         end
         ST_CAL_WAIT: begin
            // offset result stays in the front end
            if (feAns.done) begin
               // gain factor is left in the result registers, no dma request
               if (s_ff.cmdStatus[START_HI:START_LO] == START_CAL_GAIN) begin
                  nxt_s.result = {2'h0, feAns.data};
               end
               nxt_s.irqPulse = s_ff.cmdStatus[IRQ_SEL_BIT];  // see RL8
               nxt_s.cmdStatus[START_HI:START_LO] = START_IDLE;  // see RL20
               nxt_s.st = ST_IDLE;
            end
         end
         default: begin
            nxt_s.st = ST_IDLE;
         end
      endcase

      // launch of a conversion sequence, first input chosen here
      if (doConvStart) begin
         resetSamples = 1'b1;
         if (scanOn) begin
            if (scanMask != 15'h0000) begin
               nxt_s.chan    = lowestSet(scanMask);  // see RL12
               nxt_s.pending = dropBit(scanMask, lowestSet(scanMask));
               nxt_s.convReq = 1'b1;
               nxt_s.cmdStatus[START_HI:START_LO] = START_CONVERT;  // see RL2
               nxt_s.st = ST_CONV_WAIT;
            end else begin
               // nothing flagged: sequence ends at once
               nxt_s.cmdStatus[START_HI:START_LO] = START_IDLE;
               nxt_s.st = ST_IDLE;
            end
         end else begin
            nxt_s.chan    = s_ff.selLow[3:0];
            nxt_s.pending = 15'h0000;
            nxt_s.convReq = 1'b1;
            nxt_s.cmdStatus[START_HI:START_LO] = START_CONVERT;  // see RL2
            nxt_s.st = ST_CONV_WAIT;
         end
      end

      // fresh accumulator for each result
      if (resetSamples) begin
         nxt_s.acc    = 18'h00000;
         nxt_s.smpCnt = 5'h00;
      end
   end

   // ******************************************************
   // state register
   // ******************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_ff <= '{st:         ST_IDLE,
                   cmdStatus:  CMD_STATUS_RST,
                   modeConfig: MODE_CONFIG_RST,
                   selHigh:    7'h00,
                   selLow:     8'h00,
                   winUpper:   WIN_UPPER_RST,
                   winLower:   WIN_LOWER_RST,
                   result:     16'h0000,
                   dmaReq:     1'b0,
                   irqPulse:   1'b0,
                   ack:        1'b0,
                   rdData:     32'h00000000,
                   chan:       4'h0,
                   pending:    15'h0000,
                   smpCnt:     5'h00,
                   acc:        18'h00000,
                   convReq:    1'b0,
                   calReq:     1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ******************************************************
   // outputs
   // ******************************************************
   // outputs taken from the state register
   assign avs_readdata              = s_ff.rdData;
   assign dmaReq                    = s_ff.dmaReq;
   assign irqPulse                  = s_ff.irqPulse;
   assign feReq.convReq             = s_ff.convReq;
   assign feReq.calReq              = s_ff.calReq;
   assign feReq.calGain             = (s_ff.cmdStatus[START_HI:START_LO] == START_CAL_GAIN);
   assign feReq.channel             = s_ff.chan;
   assign feReq.inputArrangement    = s_ff.modeConfig[ARRANGE_HI:ARRANGE_LO];  // see RL13
   assign feReq.powerLevel          = s_ff.modeConfig[POWER_HI:POWER_LO];  // see RL11
   assign feReq.resolution14        = s_ff.modeConfig[RES_BIT];  // see RL15

endmodule : adcs_adc_control

// File: shared/adcs_pkg.sv
// shared constants, types and state layout of the converter control block
package adcs_pkg;

   // ******************************************************
   // register indices (byte address is four times the index)
   // ******************************************************
   localparam logic [11:0] IDX_CMD_STATUS  = 12'hF70;
   localparam logic [11:0] IDX_MODE_CONFIG = 12'hF71;
   localparam logic [11:0] IDX_RESULT_HIGH = 12'hF74;
   localparam logic [11:0] IDX_RESULT_LOW  = 12'hF75;
   localparam logic [11:0] IDX_SEL_HIGH    = 12'hF76;
   localparam logic [11:0] IDX_SEL_LOW     = 12'hF77;
   localparam logic [11:0] IDX_WIN_UP_HIGH = 12'hF78;
   localparam logic [11:0] IDX_WIN_UP_LOW  = 12'hF79;
   localparam logic [11:0] IDX_WIN_LO_HIGH = 12'hF7A;
   localparam logic [11:0] IDX_WIN_LO_LOW  = 12'hF7B;

   // ******************************************************
   // field positions and reset values
   // ******************************************************
   localparam int START_HI       = 7;
   localparam int START_LO       = 6;
   localparam int DMA_SEL_BIT    = 5;
   localparam int IRQ_SEL_BIT    = 4;
   localparam int CONT_BIT       = 3;
   localparam int AVG_EN_BIT     = 2;
   localparam int AVG_CNT_HI     = 1;
   localparam int AVG_CNT_LO     = 0;
   localparam int POWER_HI       = 7;
   localparam int POWER_LO       = 6;
   localparam int SCAN_BIT       = 5;
   localparam int ARRANGE_HI     = 4;
   localparam int ARRANGE_LO     = 3;
   localparam int FORMAT_BIT     = 2;
   localparam int RES_BIT        = 1;
   localparam logic [7:0]  CMD_STATUS_RST  = 8'h00;
   localparam logic [7:0]  MODE_CONFIG_RST = 8'h00;
   localparam logic [15:0] WIN_UPPER_RST   = 16'hFFFF;
   localparam logic [15:0] WIN_LOWER_RST   = 16'h0000;

   // start/busy codes and power codes
   localparam logic [1:0] START_IDLE     = 2'h0;
   localparam logic [1:0] START_CONVERT  = 2'h1;
   localparam logic [1:0] START_CAL_OFFS = 2'h2;
   localparam logic [1:0] START_CAL_GAIN = 2'h3;
   localparam logic [1:0] POWER_FAST     = 2'h0;
   localparam logic [1:0] POWER_LOW      = 2'h2;

   // result arithmetic
   localparam int          RAW_W     = 14;
   localparam int          NCHAN     = 15;
   localparam logic [15:0] MID_14BIT = 16'h2000;
   localparam logic [15:0] MID_12BIT = 16'h0800;

   typedef enum logic [1:0] {ST_IDLE, ST_CONV_WAIT, ST_CAL_WAIT} adcs_state_e;

   // request toward the analog front end
   typedef struct packed {
      logic             convReq;
      logic             calReq;
      logic             calGain;
      logic [3:0]       channel;
      logic [1:0]       inputArrangement;
      logic [1:0]       powerLevel;
      logic             resolution14;
   } adcs_fe_req_s;

   // answer from the analog front end
   typedef struct packed {
      logic             done;
      logic [RAW_W-1:0] data;
   } adcs_fe_ans_s;

   // whole state of the control block
   typedef struct packed {
      adcs_state_e st;
      logic [7:0]  cmdStatus;
      logic [7:0]  modeConfig;
      logic [6:0]  selHigh;
      logic [7:0]  selLow;
      logic [15:0] winUpper;
      logic [15:0] winLower;
      logic [15:0] result;
      logic        dmaReq;
      logic        irqPulse;
      logic        ack;
      logic [31:0] rdData;
      logic [3:0]  chan;
      logic [14:0] pending;
      logic [4:0]  smpCnt;
      logic [17:0] acc;
      logic        convReq;
      logic        calReq;
   } adcs_state_s;

endpackage : adcs_pkg

// File: bench/adcs_control_monitor.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module adcs_control_monitor
   import adcs_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire adcs_fe_req_s      feReq,
   input wire adcs_fe_ans_s      feAns,
   input wire logic              dmaReq,
   input wire logic              irqPulse
);
   // ****************
   // helper decode
   // ****************
   localparam logic [ADDR_W-1:0] A_CMD  = ADDR_W'({IDX_CMD_STATUS, 2'h0});
   localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'({IDX_MODE_CONFIG, 2'h0});
   localparam logic [ADDR_W-1:0] A_HI   = ADDR_W'({IDX_RESULT_HIGH, 2'h0});
   localparam logic [ADDR_W-1:0] A_LO   = ADDR_W'({IDX_RESULT_LOW, 2'h0});
   logic cmdTaken, modeTaken, resTaken;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // accepted accesses per register
   assign cmdTaken  = avs_write && !avs_waitrequest && avs_address == A_CMD;
   assign modeTaken = avs_write && !avs_waitrequest && avs_address == A_MODE;
   assign resTaken  = avs_read && !avs_waitrequest && (avs_address == A_HI || avs_address == A_LO);
   // ****************
   // properties
   // ****************
   sequence s_oneWait; avs_waitrequest ##1 !avs_waitrequest; endsequence
   sequence s_pulse; feReq.convReq ##1 !feReq.convReq; endsequence
   property p_oneWait; $rose(avs_read || avs_write) |-> s_oneWait; endproperty
   property p_upperZero; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   property p_convPulse; feReq.convReq |-> s_pulse; endproperty
   property p_convCause; feReq.convReq |-> $past(cmdTaken) || $past(feAns.done); endproperty
   property p_calCause;
      feReq.calReq |-> $past(cmdTaken) && $past(avs_writedata[7]) && feReq.calGain == $past(avs_writedata[6]);
   endproperty
   property p_irqCause; irqPulse |-> $past(feAns.done); endproperty
   property p_dmaCause; $rose(dmaReq) |-> $past(feAns.done); endproperty
   property p_dmaHold; dmaReq && !resTaken |=> dmaReq; endproperty
   property p_modeCause; !$stable({feReq.resolution14, feReq.inputArrangement}) |-> $past(modeTaken); endproperty
   a_oneWait: assert property (p_oneWait) else $error("wait state count wrong");
   a_upperZero: assert property (p_upperZero) else $error("upper read data not zero");
   a_convPulse: assert property (p_convPulse) else $error("sample request longer than one cycle");
   a_convCause: assert property (p_convCause) else $error("sample request without cause");
   a_calCause: assert property (p_calCause) else $error("calibration request wrong");
   a_irqCause: assert property (p_irqCause) else $error("interrupt without result");
   a_dmaCause: assert property (p_dmaCause) else $error("dma request without result");
   a_dmaHold: assert property (p_dmaHold) else $error("dma request dropped early");
   a_modeCause: assert property (p_modeCause) else $error("mode output changed alone");
endmodule : adcs_control_monitor

// File: bench/adcs_fe_model.sv
// front end stand-in answering sample and calibration requests
`timescale 1ns/1ps
module adcs_fe_model
   import adcs_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire adcs_fe_req_s feReq,
   output      adcs_fe_ans_s feAns,
   input  wire logic [13:0]  smpBase,
   input  wire logic         smpSlow,
   input  wire logic         clrIdx
);
   logic [3:0] cnt_ff;
   logic [4:0] idx_ff;
   // request loads a delay; sample k returns base plus k, idle data toggles
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 4'h0;
         idx_ff <= 5'h00;
         feAns  <= '0;
      end else begin
         feAns.done <= (cnt_ff == 4'h1);
         feAns.data <= (cnt_ff == 4'h1) ? smpBase + 14'(idx_ff) : ~feAns.data;
         if (clrIdx) idx_ff <= 5'h00;
         else if (cnt_ff == 4'h1) idx_ff <= idx_ff + 5'h01;
         if (feReq.convReq || feReq.calReq) cnt_ff <= smpSlow ? 4'h6 : 4'h1;
         else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
      end
   end
endmodule : adcs_fe_model

// File: bench/tb_adcs_adc_control.sv
// self-checking testbench of the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_adcs_adc_control
   import adcs_pkg::*;
;
   logic clk, rst_b, avsRead, avsWrite, dmaReq, irqPulse, avsWaitrequest, smpSlow, clrIdx;
   logic [13:0] avsAddress, smpBase;
   logic [31:0] avsWritedata, avsReaddata;
   logic [15:0] winUp;
   logic [3:0]  lastChan;
   adcs_fe_req_s feReq;
   adcs_fe_ans_s feAns;
   int errors, nCompared, seed, irqCnt, convCnt;
   adcs_adc_control u_dut (.clk(clk), .rst_b(rst_b), .avs_address(avsAddress), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWaitrequest), .feReq(feReq), .feAns(feAns), .dmaReq(dmaReq), .irqPulse(irqPulse));
   adcs_fe_model u_fe (.clk(clk), .rst_b(rst_b), .feReq(feReq), .feAns(feAns), .smpBase(smpBase),
      .smpSlow(smpSlow), .clrIdx(clrIdx));
   // clock, watchdog and event counters
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      testDone();
   end
   always @(negedge clk) begin
      if (irqPulse === 1'b1) irqCnt++;
      if (feReq.convReq === 1'b1) begin
         convCnt++;
         lastChan = feReq.channel;
      end
   end
   // ****************
   // bus tasks and expectations
   // ****************
   task automatic testDone();
      $display("compared %0d, errors %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : testDone
   task automatic bus(input logic [11:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
      int i;
      @(posedge clk);
      avsAddress   <= {idx, 2'h0};
      avsRead      <= !wr;
      avsWrite     <= wr;
      avsWritedata <= {24'h0, wd};
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (avsWaitrequest === 1'b0) break;
      end
      if (i == 50) begin
         errors++;
         testDone();
      end
      rd = avsReaddata[7:0];
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus
   task automatic wr8(input logic [11:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(idx, 1'b1, d, x);
   endtask : wr8
   task automatic rd8(input logic [11:0] idx, output logic [7:0] d);
      bus(idx, 1'b0, 8'h00, d);
   endtask : rd8
   task automatic waitIdle();
      logic [7:0] s;
      int i;
      for (i = 0; i < 100; i++) begin
         rd8(IDX_CMD_STATUS, s);
         if (s[7:6] === 2'h0) break;
      end
      `CHK("idle", 2'h0, s[7:6])
      if (i == 100) testDone();
   endtask : waitIdle
   // unsigned mean of base..base+n-1 at the chosen resolution
   function automatic logic [15:0] plainVal(logic [7:0] c, logic [7:0] m, logic [13:0] b);
      int sh;
      int n;
      logic [31:0] sum;
      sh  = c[2] ? c[1:0] + 1 : 0;
      n   = 1 << sh;
      sum = (n * b + n * (n - 1) / 2) >> sh;
      return m[1] ? {2'h0, sum[13:0]} : {4'h0, sum[13:2]};
   endfunction : plainVal
   task automatic runConv(input logic [7:0] c, input logic [7:0] m, input logic [13:0] b);
      logic [7:0] r1, r2, s;
      logic [15:0] p, e;
      int irq0 = irqCnt;
      p = plainVal(c, m, b);
      e = m[2] ? p - (m[1] ? MID_14BIT : MID_12BIT) : p;
      smpBase <= b;
      clrIdx  <= 1'b1;
      wr8(IDX_MODE_CONFIG, m);
      clrIdx <= 1'b0;
      wr8(IDX_CMD_STATUS, c);
      rd8(IDX_CMD_STATUS, s);
      if (smpSlow) `CHK("busy", 2'h1, s[7:6])
      waitIdle();
      `CHK("dma set", 1'b1, dmaReq)
      rd8(c[5] ? IDX_RESULT_LOW : IDX_RESULT_HIGH, r1);
      @(negedge clk);
      `CHK("dma kept", 1'b1, dmaReq)
      rd8(c[5] ? IDX_RESULT_HIGH : IDX_RESULT_LOW, r2);
      @(negedge clk);
      `CHK("dma clear", 1'b0, dmaReq)
      `CHK("result", e, c[5] ? {r2, r1} : {r1, r2})
      `CHK("irq", (c[4] || p > winUp) ? 1 : 0, irqCnt - irq0)
   endtask : runConv
   // ****************
   // main sequence
   // ****************
   initial begin
      logic [7:0] d, c, m, hi, lo;
      int i, j;
      {avsRead, avsWrite, avsAddress, avsWritedata, smpBase, clrIdx} = '0;
      {errors, nCompared, irqCnt, convCnt} = '0;
      seed = 97;
      smpSlow = 1'b1;
      winUp = 16'hFFFF;
      rst_b = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rd8(IDX_CMD_STATUS, d);
      `CHK("cmd reset", CMD_STATUS_RST, d)
      rd8(IDX_MODE_CONFIG, d);
      `CHK("mode reset", MODE_CONFIG_RST, d)
      rd8(12'hF7F, d);
      `CHK("unmapped", 8'h00, d)
      wr8(IDX_MODE_CONFIG, 8'h81);
      wr8(IDX_MODE_CONFIG, 8'h41);
      rd8(IDX_MODE_CONFIG, d);
      `CHK("power kept", 8'h81, d)
      `CHK("power level", POWER_LOW, feReq.powerLevel)
      for (i = 0; i < 4; i++) begin
         wr8(IDX_MODE_CONFIG, {3'h0, 2'(i), 1'b0, 1'(i), 1'b1});
         repeat (2) @(negedge clk);
         `CHK("arrangement", 2'(i), feReq.inputArrangement)
         `CHK("resolution", 1'(i), feReq.resolution14)
      end
      for (i = 0; i < 12; i++) begin
         c = $random(seed);
         m = $random(seed);
         smpSlow <= i[0];
         runConv({2'h1, c[5:4], 1'b0, c[2:0]}, {m[7], 2'h0, m[4:1], 1'b1}, 14'($random(seed)) & 14'h3FE0);
      end
      wr8(IDX_WIN_UP_HIGH, 8'h01);
      wr8(IDX_WIN_UP_LOW, 8'h00);
      winUp = 16'h0100;
      runConv(8'h40, 8'h03, 14'h3000);
      runConv(8'h40, 8'h03, 14'h0040);
      for (i = 0; i < 2; i++) begin
         j = irqCnt;
         smpBase <= 14'h1234;
         clrIdx  <= 1'b1;
         wr8(IDX_MODE_CONFIG, 8'h03);
         clrIdx <= 1'b0;
         wr8(IDX_CMD_STATUS, {1'b1, 1'(i), 2'h1, 4'h0});
         rd8(IDX_CMD_STATUS, d);
         `CHK("cal busy", {1'b1, 1'(i)}, d[7:6])
         waitIdle();
         `CHK("cal irq", j + 1, irqCnt)
         `CHK("cal dma", 1'b0, dmaReq)
      end
      rd8(IDX_RESULT_HIGH, hi);
      rd8(IDX_RESULT_LOW, lo);
      `CHK("gain factor", 16'h1234, {hi, lo})
      wr8(IDX_SEL_LOW, 8'h05);
      wr8(IDX_MODE_CONFIG, 8'h23);
      j = convCnt;
      wr8(IDX_CMD_STATUS, 8'h40);
      waitIdle();
      `CHK("scan count", 2, convCnt - j)
      `CHK("scan channel", 4'h2, lastChan)
      wr8(IDX_MODE_CONFIG, 8'h03);
      j = convCnt;
      wr8(IDX_CMD_STATUS, 8'h48);
      repeat (60) @(posedge clk);
      wr8(IDX_CMD_STATUS, 8'h00);
      waitIdle();
      `CHK("restarts", 1'b1, convCnt - j > 3)
      testDone();
   end
endmodule : tb_adcs_adc_control
bind adcs_adc_control adcs_control_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk(clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .feReq(feReq), .feAns(feAns),
   .dmaReq(dmaReq), .irqPulse(irqPulse));
